// ===== src/tmw_defines.vh
// Purpose: constants for the 16-bit timer waveform and output-mode block
// Assumes: registers reached over a plain address/strobe port
// Notes: byte-wide registers, offsets as in the register map
// Summary of operation
// (R1) Synchronous logic, tick acts as enable
// (R2) Freq-correct modes reload and flag at BOTTOM
// (R3) Nonzero out_mode_a overrides pin, direction gates drive
// (R4) Nonzero out_mode_b overrides pin, direction gates drive
// (R5) Non-PWM: off, toggle, clear, set on match
// (R6) Fast PWM mode 1 toggles A only in 14/15
// (R7) Fast PWM: 2 non-inverting, 3 inverting
// (R8) Fast PWM: match at TOP ignored, BOTTOM acts
// (R9) Dual-slope mode 1 toggles A only in 9/11
// (R10) Dual-slope: 2 clears up, sets down; 3 reverse
// (R11) wave_mode from ctrl_a low and ctrl_b high bits
// (R12) Mode 0: TOP 0xFFFF, immediate, flag at MAX
// (R13) Modes 4/12: TOP compare_a/capture, immediate, MAX flag
// (R14) Phase-correct modes: reload at TOP, flag at BOTTOM
// (R15) Fast PWM modes: reload at BOTTOM, flag at TOP
// (R16) Modes 8/9: freq-correct, reload and flag at BOTTOM
// (R17) High mode bits at 4:3 of ctrl_b, 0x81
// (R18) Dual-slope counts BOTTOM to TOP and back
// (R19) Mode 13 reserved, handled as normal
// (R20) ctrl_a bits 3:2 read zero, all reset zero
`ifndef TMW_DEFINES_VH
`define TMW_DEFINES_VH
`define TMW_ADR_CTRL_A 8'h80
`define TMW_ADR_CTRL_B 8'h81
`define TMW_ADR_CNT_L 8'h84
`define TMW_ADR_CNT_H 8'h85
`define TMW_ADR_CAP_L 8'h86
`define TMW_ADR_CAP_H 8'h87
`define TMW_ADR_CMPA_L 8'h88
`define TMW_ADR_CMPA_H 8'h89
`define TMW_ADR_CMPB_L 8'h8a
`define TMW_ADR_CMPB_H 8'h8b
`define TMW_ADR_STATUS 8'h36
`define TMW_ADR_DIR 8'h90
`define TMW_CTRL_A_MASK 8'hf3
`define TMW_CTRL_B_MASK 8'hdf
`define TMW_BOTTOM 16'h0000
`define TMW_MAX 16'hffff
`define TMW_TOP8 16'h00ff
`define TMW_TOP9 16'h01ff
`define TMW_TOP10 16'h03ff
`define TMW_OM_OFF 2'h0
`define TMW_OM_TOG 2'h1
`define TMW_OM_CLR 2'h2
`define TMW_OM_SET 2'h3
`define TMW_K_NORMAL 3'h0
`define TMW_K_CTC 3'h1
`define TMW_K_FAST 3'h2
`define TMW_K_PC 3'h3
`define TMW_K_PFC 3'h4
`define TMW_TS_FIXED 2'h0
`define TMW_TS_CMPA 2'h1
`define TMW_TS_CAP 2'h2
`endif

// ===== src/tmw_mode_decode.v
// Purpose: decode wave_mode into kind and TOP value
// Assumes: combinational only
// Notes: reserved mode 13 falls back to normal
`timescale 1ns/1ns
`include "tmw_defines.vh"
module tmw_mode_decode (
  wave_mode,
  compare_val_a,
  capture_val,
  kind,
  top_value
);
  input wire [3:0] wave_mode;
  input wire [15:0] compare_val_a;
  input wire [15:0] capture_val;
  output reg [2:0] kind;
  output reg [15:0] top_value;
  always @* begin
    kind = `TMW_K_NORMAL;
    top_value = `TMW_MAX;
    case (wave_mode)
      // (R13) clear_on_match TOP
      4'h4: begin
        kind = `TMW_K_CTC;
        top_value = compare_val_a;
      end
      4'hc: begin
        kind = `TMW_K_CTC;
        top_value = capture_val;
      end
      // (R14) phase-correct kinds
      4'h1: begin
        kind = `TMW_K_PC;
        top_value = `TMW_TOP8;
      end
      4'h2: begin
        kind = `TMW_K_PC;
        top_value = `TMW_TOP9;
      end
      4'h3: begin
        kind = `TMW_K_PC;
        top_value = `TMW_TOP10;
      end
      4'ha: begin
        kind = `TMW_K_PC;
        top_value = capture_val;
      end
      4'hb: begin
        kind = `TMW_K_PC;
        top_value = compare_val_a;
      end
      // (R15) fast PWM kinds
      4'h5: begin
        kind = `TMW_K_FAST;
        top_value = `TMW_TOP8;
      end
      4'h6: begin
        kind = `TMW_K_FAST;
        top_value = `TMW_TOP9;
      end
      4'h7: begin
        kind = `TMW_K_FAST;
        top_value = `TMW_TOP10;
      end
      4'he: begin
        kind = `TMW_K_FAST;
        top_value = capture_val;
      end
      4'hf: begin
        kind = `TMW_K_FAST;
        top_value = compare_val_a;
      end
      // (R16) freq-correct kinds
      4'h8: begin
        kind = `TMW_K_PFC;
        top_value = capture_val;
      end
      4'h9: begin
        kind = `TMW_K_PFC;
        top_value = compare_val_a;
      end
      // (R12) normal, (R19) reserved 13 too
      default: begin
        kind = `TMW_K_NORMAL;
        top_value = `TMW_MAX;
      end
    endcase
  end
endmodule

// ===== src/tmw_wave_out.v
// Purpose: one compare output waveform register
// Assumes: match and edge events already qualified by tick
// Notes: instanced once per channel
`timescale 1ns/1ns
`include "tmw_defines.vh"
module tmw_wave_out (
  ref_clk,
  reset_n,
  out_mode,
  kind,
  toggle_ok,
  match,
  at_bottom,
  top_match,
  counting_up,
  wave_out
);
  input wire ref_clk;
  input wire reset_n;
  input wire [1:0] out_mode;
  input wire [2:0] kind;
  input wire toggle_ok;
  input wire match;
  input wire at_bottom;
  input wire top_match;
  input wire counting_up;
  output reg wave_out;
  reg next_wave_out;
  always @* begin
    next_wave_out = wave_out;
    case (kind)
      `TMW_K_FAST: begin
        // (R6) toggle only when allowed
        if (out_mode == `TMW_OM_TOG && match && toggle_ok)
          next_wave_out = ~wave_out;
        // (R7) match then BOTTOM action
        if (out_mode[1]) begin
          // (R8) match at TOP ignored
          if (match && !top_match)
            next_wave_out = out_mode[0];
          if (at_bottom)
            next_wave_out = ~out_mode[0];
        end
      end
      `TMW_K_PC, `TMW_K_PFC: begin
        // (R9) toggle only when allowed
        if (out_mode == `TMW_OM_TOG && match && toggle_ok)
          next_wave_out = ~wave_out;
        // (R10) direction picks level
        if (out_mode[1] && match)
          next_wave_out = counting_up ? out_mode[0] : ~out_mode[0];
      end
      default: begin
        // (R5) non-PWM actions
        if (match) begin
          case (out_mode)
            `TMW_OM_TOG: next_wave_out = ~wave_out;
            `TMW_OM_CLR: next_wave_out = 1'b0;
            `TMW_OM_SET: next_wave_out = 1'b1;
            default: next_wave_out = wave_out;
          endcase
        end
      end
    endcase
  end
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      wave_out <= 1'b0;
    else
      wave_out <= next_wave_out;
  end
endmodule

// ===== src/tmw_timer.v
// Purpose: 16-bit timer waveform generation and compare outputs
// Assumes: tick_enable is synchronous to ref_clk; counts on every cycle it is high
// Notes: 16-bit registers written per byte, no shared temp byte
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "tmw_defines.vh"
module tmw_timer (
  ref_clk,
  reset_n,
  tick_enable,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  port_data_a,
  port_data_b,
  pin_a_out,
  pin_a_oe,
  pin_b_out,
  pin_b_oe,
  overflow_flag,
  compare_flag_a,
  compare_flag_b
);
  parameter W = 16;
  input wire ref_clk;
  input wire reset_n;
  input wire tick_enable;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  input wire port_data_a;
  input wire port_data_b;
  output reg pin_a_out;
  output reg pin_a_oe;
  output reg pin_b_out;
  output reg pin_b_oe;
  output reg overflow_flag;
  output reg compare_flag_a;
  output reg compare_flag_b;

  reg [7:0] waveform_ctrl_a;
  reg [7:0] waveform_ctrl_b;
  reg [1:0] pin_direction_bit;
  reg [W-1:0] count_value;
  reg [W-1:0] capture_val;
  reg [W-1:0] compare_val_a;
  reg [W-1:0] compare_val_b;
  reg [W-1:0] buf_a;
  reg [W-1:0] buf_b;
  reg counting_up;
  wire [3:0] wave_mode;
  wire [1:0] out_mode_a;
  wire [1:0] out_mode_b;
  wire [2:0] kind;
  wire [W-1:0] top_value;
  wire wave_out_a;
  wire wave_out_b;

  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      wr_hit = reg_wr && (a == target);
    end
  endfunction

  // PWM toggle takes the pin only where the mode allows it
  function pin_takeover;
    input [1:0] om;
    input [2:0] k;
    input tog;
    begin
      if (om[1])
        pin_takeover = 1'b1;
      else if (om[0])
        pin_takeover = (k == `TMW_K_NORMAL) || (k == `TMW_K_CTC) || tog;
      else
        pin_takeover = 1'b0;
    end
  endfunction

  // (R11) mode assembled from two registers
  // (R17) high bits at 4:3 of ctrl_b
  assign wave_mode = {waveform_ctrl_b[4:3], waveform_ctrl_a[1:0]};
  assign out_mode_a = waveform_ctrl_a[7:6];
  assign out_mode_b = waveform_ctrl_a[5:4];

  tmw_mode_decode u_dec (
    .wave_mode(wave_mode),
    .compare_val_a(compare_val_a),
    .capture_val(capture_val),
    .kind(kind),
    .top_value(top_value)
  );

  wire dual = (kind == `TMW_K_PC) || (kind == `TMW_K_PFC);
  wire at_top = (count_value == top_value);
  wire at_bot = (count_value == `TMW_BOTTOM);
  wire at_max = (count_value == `TMW_MAX);
  // Dual-slope turns at TOP even before direction register flips
  wire dir_up = dual ? (counting_up && !at_top) || at_bot : 1'b1;
  wire [W-1:0] next_count = dual ?
    (dir_up ? count_value + 16'h0001 : count_value - 16'h0001) :
    ((at_top && kind != `TMW_K_NORMAL) ? `TMW_BOTTOM :
     count_value + 16'h0001);
  wire match_a = tick_enable && (count_value == compare_val_a);
  wire match_b = tick_enable && (count_value == compare_val_b);
  // Bottom action fires as the counter wraps to BOTTOM
  wire fast_wrap = tick_enable && (kind == `TMW_K_FAST) && at_top;
  wire tog_a = (kind == `TMW_K_FAST) ? wave_mode[3:1] == 3'h7 :
    (wave_mode == 4'h9 || wave_mode == 4'hb);

  tmw_wave_out u_out_a (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .out_mode(out_mode_a),
    .kind(kind),
    .toggle_ok(tog_a),
    .match(match_a),
    .at_bottom(fast_wrap),
    .top_match(compare_val_a == top_value),
    .counting_up(dir_up),
    .wave_out(wave_out_a)
  );

  tmw_wave_out u_out_b (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .out_mode(out_mode_b),
    .kind(kind),
    .toggle_ok(1'b0),
    .match(match_b),
    .at_bottom(fast_wrap),
    .top_match(compare_val_b == top_value),
    .counting_up(dir_up),
    .wave_out(wave_out_b)
  );

  // Reload instants per mode
  reg reload_now;
  reg ovf_now;
  always @* begin
    reload_now = 1'b0;
    ovf_now = 1'b0;
    case (kind)
      // (R15) reload BOTTOM, flag TOP
      `TMW_K_FAST: begin
        reload_now = at_top;
        ovf_now = at_top;
      end
      // (R14) reload TOP, flag BOTTOM
      `TMW_K_PC: begin
        reload_now = at_top;
        ovf_now = at_bot && !counting_up;
      end
      // (R2) reload and flag at BOTTOM
      `TMW_K_PFC: begin
        reload_now = at_bot && !counting_up;
        ovf_now = at_bot && !counting_up;
      end
      // (R12) (R13) flag at MAX
      default: begin
        reload_now = 1'b0;
        ovf_now = at_max;
      end
    endcase
  end

  wire buffered = (kind != `TMW_K_NORMAL) && (kind != `TMW_K_CTC);

  // (R1) counter moves on tick only; register writes and immediate compare copy act every cycle
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_value <= `TMW_BOTTOM;
      counting_up <= 1'b1;
      compare_val_a <= `TMW_BOTTOM;
      compare_val_b <= `TMW_BOTTOM;
    end else begin
      if (wr_hit(reg_addr, `TMW_ADR_CNT_L))
        count_value[7:0] <= reg_wdata;
      else if (wr_hit(reg_addr, `TMW_ADR_CNT_H))
        count_value[15:8] <= reg_wdata;
      else if (tick_enable) begin
        // (R18) dual-slope up and down
        count_value <= next_count;
        counting_up <= dir_up;
      end
      // Immediate modes bypass the buffer
      if (!buffered) begin
        compare_val_a <= buf_a;
        compare_val_b <= buf_b;
      end else if (tick_enable && reload_now) begin
        compare_val_a <= buf_a;
        compare_val_b <= buf_b;
      end
    end
  end

  // Registers and sticky flags; hardware set beats software clear
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      waveform_ctrl_a <= 8'h00;
      waveform_ctrl_b <= 8'h00;
      pin_direction_bit <= 2'h0;
      capture_val <= `TMW_BOTTOM;
      buf_a <= `TMW_BOTTOM;
      buf_b <= `TMW_BOTTOM;
      overflow_flag <= 1'b0;
      compare_flag_a <= 1'b0;
      compare_flag_b <= 1'b0;
    end else begin
      // (R20) reserved bits stay zero
      if (wr_hit(reg_addr, `TMW_ADR_CTRL_A))
        waveform_ctrl_a <= reg_wdata & `TMW_CTRL_A_MASK;
      if (wr_hit(reg_addr, `TMW_ADR_CTRL_B))
        waveform_ctrl_b <= reg_wdata & `TMW_CTRL_B_MASK;
      if (wr_hit(reg_addr, `TMW_ADR_DIR))
        pin_direction_bit <= reg_wdata[1:0];
      if (wr_hit(reg_addr, `TMW_ADR_CAP_L))
        capture_val[7:0] <= reg_wdata;
      if (wr_hit(reg_addr, `TMW_ADR_CAP_H))
        capture_val[15:8] <= reg_wdata;
      if (wr_hit(reg_addr, `TMW_ADR_CMPA_L))
        buf_a[7:0] <= reg_wdata;
      if (wr_hit(reg_addr, `TMW_ADR_CMPA_H))
        buf_a[15:8] <= reg_wdata;
      if (wr_hit(reg_addr, `TMW_ADR_CMPB_L))
        buf_b[7:0] <= reg_wdata;
      if (wr_hit(reg_addr, `TMW_ADR_CMPB_H))
        buf_b[15:8] <= reg_wdata;
      // Write one to clear
      overflow_flag <= (overflow_flag &&
        !(wr_hit(reg_addr, `TMW_ADR_STATUS) && reg_wdata[0])) ||
        (tick_enable && ovf_now);
      compare_flag_a <= (compare_flag_a &&
        !(wr_hit(reg_addr, `TMW_ADR_STATUS) && reg_wdata[1])) ||
        match_a;
      compare_flag_b <= (compare_flag_b &&
        !(wr_hit(reg_addr, `TMW_ADR_STATUS) && reg_wdata[2])) ||
        match_b;
    end
  end

  // Pin mux registered so outputs come from flops; one cycle late
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_a_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_out <= 1'b0;
      pin_b_oe <= 1'b0;
    end else begin
      // (R3) (R6) (R9) override then direction gate
      pin_a_out <= pin_takeover(out_mode_a, kind, tog_a) ?
        wave_out_a : port_data_a;
      pin_a_oe <= pin_direction_bit[0];
      // (R4) (R6) (R9) B never toggles in PWM
      pin_b_out <= pin_takeover(out_mode_b, kind, 1'b0) ?
        wave_out_b : port_data_b;
      pin_b_oe <= pin_direction_bit[1];
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        `TMW_ADR_CTRL_A: reg_rdata <= waveform_ctrl_a;
        `TMW_ADR_CTRL_B: reg_rdata <= waveform_ctrl_b;
        `TMW_ADR_CNT_L: reg_rdata <= count_value[7:0];
        `TMW_ADR_CNT_H: reg_rdata <= count_value[15:8];
        `TMW_ADR_CAP_L: reg_rdata <= capture_val[7:0];
        `TMW_ADR_CAP_H: reg_rdata <= capture_val[15:8];
        `TMW_ADR_CMPA_L: reg_rdata <= buf_a[7:0];
        `TMW_ADR_CMPA_H: reg_rdata <= buf_a[15:8];
        `TMW_ADR_CMPB_L: reg_rdata <= buf_b[7:0];
        `TMW_ADR_CMPB_H: reg_rdata <= buf_b[15:8];
        `TMW_ADR_STATUS:
          reg_rdata <= {5'h00, compare_flag_b, compare_flag_a,
            overflow_flag};
        `TMW_ADR_DIR: reg_rdata <= {6'h00, pin_direction_bit};
        default: reg_rdata <= 8'h00;
      endcase
    end else
      reg_rdata <= 8'h00;
  end
endmodule

// ===== bench/tmw_timer_asserts.sv
// Purpose: port-level checks for the timer waveform block
// Assumes: status at 0x36 is write-one-to-clear, dir at 0x90
// Notes: compare events inside the block are not visible here
`timescale 1ns/1ns
module tmw_timer_asserts (
  input wire ref_clk,
  input wire reset_n,
  input wire tick_enable,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire pin_a_oe,
  input wire pin_b_oe,
  input wire overflow_flag,
  input wire compare_flag_a,
  input wire compare_flag_b
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence rd_at(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence clr_ovf;
    reg_wr && reg_addr == 8'h36 && reg_wdata[0];
  endsequence
  sequence dir_both;
    reg_wr && reg_addr == 8'h90 && reg_wdata[1:0] == 2'h3;
  endsequence
  rdata_idle_a:
  assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  ctrl_a_rsvd_a:
  assert property (rd_at(8'h80) |=> reg_rdata[3:2] == 2'h0)
    else $error("control a reserved bits set");
  ctrl_b_rsvd_a:
  assert property (rd_at(8'h81) |=> !reg_rdata[5])
    else $error("control b reserved bit set");
  ovf_tick_a:
  assert property ($rose(overflow_flag) |-> $past(tick_enable))
    else $error("overflow set without tick");
  cmpa_tick_a:
  assert property ($rose(compare_flag_a) |-> $past(tick_enable))
    else $error("compare a set without tick");
  cmpb_tick_a:
  assert property (!tick_enable && !compare_flag_b |=> !compare_flag_b)
    else $error("compare b set without tick");
  // Set wins a tie, so only tickless clears are judged
  ovf_clear_a:
  assert property (clr_ovf ##0 !tick_enable |=> !overflow_flag)
    else $error("overflow not cleared");
  ovf_hold_a:
  assert property ($fell(overflow_flag) |->
    $past(reg_wr && reg_addr == 8'h36 && reg_wdata[0]))
    else $error("overflow dropped without clear");
  oe_set_a:
  assert property (dir_both |-> ##[1:2] pin_a_oe && pin_b_oe)
    else $error("drive enable not taken");
endmodule
bind tmw_timer tmw_timer_asserts chk_u (.ref_clk, .reset_n,
  .tick_enable, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .pin_a_oe, .pin_b_oe, .overflow_flag, .compare_flag_a,
  .compare_flag_b);

// ===== bench/tmw_pin_model.sv
// Purpose: external pin fed by one compare output
// Assumes: no pull resistor on the pin
// Notes: undriven pin flips every cycle so stale values never match
`timescale 1ns/1ns
module tmw_pin_model (
  input wire ref_clk,
  input wire drv,
  input wire oe,
  output wire level
);
  reg last = 1'h0;
  assign level = oe ? drv : ~last;
  always @(posedge ref_clk) begin
    last <= level;
  end
endmodule

// ===== bench/test_tmw_timer.sv
// Purpose: self-checking bench for the timer waveform block
// Assumes: pins seen through the pin models, both drivers enabled
// Notes: cases run in order, each relies on the pin state left before
`timescale 1ns/1ns
module test_tmw_timer;
  reg ref_clk = 1'h0;
  reg reset_n = 1'h0;
  reg tick_enable = 1'h0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'h0;
  reg reg_rd = 1'h0;
  reg port_data_a = 1'h1;
  reg port_data_b = 1'h0;
  wire [7:0] reg_rdata;
  wire pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
  wire overflow_flag, compare_flag_a, compare_flag_b;
  wire lvl_a, lvl_b;
  integer failures = 0;
  integer checks = 0;
  always #4 ref_clk = ~ref_clk;
  tmw_timer dut_u (.ref_clk, .reset_n, .tick_enable, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_data_a,
    .port_data_b, .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe,
    .overflow_flag, .compare_flag_a, .compare_flag_b);
  tmw_pin_model pin_a_u (.ref_clk, .drv(pin_a_out), .oe(pin_a_oe),
    .level(lvl_a));
  tmw_pin_model pin_b_u (.ref_clk, .drv(pin_b_out), .oe(pin_b_oe),
    .level(lvl_b));
  task chk(input bit ok, input string m);
    checks = checks + 1;
    if (!ok) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  // One strobe cycle, read data judged in the slot after it
  task acc(input bit w, input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    #1;
    if (!w) chk(reg_rdata === d, "read data");
  endtask
  // Pins lag the wave by a cycle, so settle before looking
  task ticks(input [15:0] n);
    @(posedge ref_clk);
    tick_enable <= 1'h1;
    repeat (n) @(posedge ref_clk);
    tick_enable <= 1'h0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task reg_test;
    acc(1'h0, 8'h80, 8'h00);
    acc(1'h0, 8'h81, 8'h00);
    acc(1'h1, 8'h80, 8'hff);
    acc(1'h0, 8'h80, 8'hf3);
    acc(1'h1, 8'h81, 8'hff);
    acc(1'h0, 8'h81, 8'hdf);
    acc(1'h1, 8'h81, 8'h00);
    acc(1'h1, 8'h80, 8'h00);
    acc(1'h0, 8'h00, 8'h00);
    acc(1'h1, 8'h90, 8'h03);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(pin_a_oe === 1'h1 && pin_b_oe === 1'h1, "drive enable");
    $display("register test done");
  endtask
  // Compare written after the mode, so buffered modes hold it back
  task wave_case(input [7:0] ca, cb, input [15:0] cnt, cmp, n1, n2,
    input [2:0] e1, e2);
    int i;
    acc(1'h1, 8'h80, ca);
    acc(1'h1, 8'h81, cb);
    acc(1'h1, 8'h85, cnt[15:8]);
    acc(1'h1, 8'h84, cnt[7:0]);
    for (i = 0; i < 4; i++) begin
      acc(1'h1, 8'h88 + i[7:0], i[0] ? cmp[15:8] : cmp[7:0]);
    end
    acc(1'h1, 8'h36, 8'h07);
    ticks(n1);
    chk({lvl_a, lvl_b, overflow_flag} === e1, "first look");
    ticks(n2);
    chk({lvl_a, lvl_b, overflow_flag} === e2, "second look");
    $display("wave case %h %h done", ca, cb);
  endtask
  task tally_and_finish;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'h1;
    reg_test;
    // Reserved mode never selected
    wave_case(8'hf0, 8'h00, 16'hfff0, 16'hfffa, 16'h0008, 16'h0010,
      3'h0, 3'h7);
    wave_case(8'h80, 8'h08, 16'h0030, 16'h0040, 16'h0008, 16'h0020,
      3'h4, 3'h0);
    wave_case(8'h40, 8'h00, 16'h0000, 16'h0010, 16'h0008, 16'h0010,
      3'h0, 3'h4);
    wave_case(8'hc1, 8'h08, 16'h00f0, 16'h0080, 16'h0028, 16'h0070,
      3'h1, 3'h5);
    wave_case(8'h83, 8'h08, 16'h03f0, 16'h0100, 16'h0028, 16'h0110,
      3'h5, 3'h1);
    wave_case(8'h81, 8'h00, 16'h00f0, 16'h0080, 16'h0020, 16'h0100,
      3'h0, 3'h5);
    wave_case(8'h41, 8'h10, 16'h0030, 16'h0040, 16'h0040, 16'h00c8,
      3'h4, 3'h1);
    wave_case(8'h51, 8'h08, 16'h00f0, 16'h0040, 16'h0028, 16'h0008,
      3'h5, 3'h5);
    // Capture as TOP, toggle allowed on A only
    acc(1'h1, 8'h86, 8'h40);
    acc(1'h1, 8'h87, 8'h00);
    acc(1'h0, 8'h86, 8'h40);
    wave_case(8'h52, 8'h18, 16'h0030, 16'h0040, 16'h0018, 16'h0041,
      3'h5, 3'h1);
    acc(1'h0, 8'h36, 8'h07);
    acc(1'h1, 8'h36, 8'h07);
    acc(1'h0, 8'h36, 8'h00);
    tally_and_finish;
  end
endmodule
